// ### shared/c16ss_consts.vh
`ifndef C16SS_CONSTS_VH
`define C16SS_CONSTS_VH
`define C16SS_ADDR_W       26
`define C16SS_DATA_W       16
`define C16SS_FIFO_DEPTH   16
`define C16SS_TCYC_NS      30
`define C16SS_SU_MEM_MIN   3'h1
`define C16SS_SU_IO_MIN    3'h2
`define C16SS_SU_IOW_MIN   3'h3
`define C16SS_SU_MAX       3'h7
`define C16SS_PW_MIN       5'h03
`define C16SS_HL_MIN       3'h1
`define C16SS_WDATA_LAG    3'h2
`define C16SS_CE_LAG       3'h1
`define C16SS_CMD_W        47
`define C16SS_CMD_WR       46
`define C16SS_CMD_IO       45
`define C16SS_CMD_REG      44
`define C16SS_CMD_CEH      43
`define C16SS_CMD_CEL      42
`define C16SS_CMD_ADDR_HI  41
`define C16SS_CMD_ADDR_LO  16
`define C16SS_CMD_DATA_HI  15
`define C16SS_CMD_DATA_LO  0
`define C16SS_TMG_SU_HI    2
`define C16SS_TMG_SU_LO    0
`define C16SS_TMG_PW_HI    7
`define C16SS_TMG_PW_LO    3
`define C16SS_TMG_HL_HI    10
`define C16SS_TMG_HL_LO    8
`endif

// ### hw/c16ss_fifo.v
module c16ss_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   reg             rdy_q;
   wire [AW:0]     cnt_d;
   wire            push;
   wire            pop;
   // ready is registered from the next count so the port comes from a flop
   assign in_ready_o  = rdy_q;
   assign cnt_d       = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop  = out_valid_o & out_ready_i;
   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_q] <= in_data_i;
      end
   end
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         rdy_q <= 1'b1;
      end else begin
         if (push) begin
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         cnt_q <= cnt_d;
         rdy_q <= (cnt_d != DEPTH[AW:0]);
      end
   end
endmodule // c16ss_fifo

// ### hw/c16ss_sequencer.v
// Notes on behaviour
// - all timing counted in 30 ns clocks
// - memory address setup 1-7 before strobe
// - memory strobe low 3-31 clocks
// - address held 1-7 after strobe rises
// - memory write data follows setup and hold
// - memory timing from programmable register
// - I/O timing from separate programmable register
// - I/O address setup 2-7 before strobe, 3-7 for writes
// - I/O strobe low 3-31 clocks
// - I/O address held 1-7 after strobe
// - I/O card enables one clock after address
// - I/O write data leads by setup minus two
// - wait request extends strobe, release after one
`include "c16ss_consts.vh"
module c16ss_sequencer #(
   parameter AW    = `C16SS_ADDR_W,
   parameter DW    = `C16SS_DATA_W,
   parameter DEPTH = `C16SS_FIFO_DEPTH
) (
   input  wire                  clk_sys_i,
   input  wire                  rst_n_i,
   input  wire                  cmd_valid_i,
   output wire                  cmd_ready_o,
   input  wire                  cmd_write_i,
   input  wire                  cmd_io_i,
   input  wire                  cmd_attr_i,
   input  wire [1:0]            cmd_ce_i,
   input  wire [AW-1:0]         cmd_addr_i,
   input  wire [DW-1:0]         cmd_wdata_i,
   input  wire [10:0]           mem_timing_i,
   input  wire [10:0]           io_timing_i,
   output reg                   done_o,
   output reg  [DW-1:0]         rdata_o,
   output reg                   rd_acked_o,
   output reg                   port16_o,
   output reg                   busy_o,
   output reg  [AW-1:0]         card_address_o,
   output reg                   attr_sel_n_o,
   output reg  [1:0]            card_enable_n_o,
   output reg                   mem_read_strobe_n_o,
   output reg                   mem_write_strobe_n_o,
   output reg                   io_read_strobe_n_o,
   output reg                   io_write_strobe_n_o,
   input  wire [DW-1:0]         card_data_bus_i,
   output reg  [DW-1:0]         card_data_bus_o,
   output reg                   card_data_bus_oe_o,
   input  wire                  card_wait_n_i,
   input  wire                  io_port_width16_n_i,
   input  wire                  input_port_acknowledge_n_i
);
   localparam ST_IDLE  = 2'h0;
   localparam ST_SETUP = 2'h1;
   localparam ST_PULSE = 2'h2;
   localparam ST_HOLD  = 2'h3;

   reg                   rst_s1_q;
   reg                   rst_s2_q;
   wire                  rst_n;
   reg  [2:0]            wait_s_q;
   reg  [2:0]            w16_s_q;
   reg  [2:0]            ack_s_q;
   wire                  wait_act;
   wire                  f_valid;
   reg                   f_ready;
   wire [`C16SS_CMD_W-1:0] f_data;
   reg  [1:0]            st_q;
   reg  [4:0]            cnt_q;
   reg  [2:0]            su_q;
   reg  [4:0]            pw_q;
   reg  [2:0]            hl_q;
   reg                   wr_q;
   reg                   io_q;
   reg  [1:0]            ce_q;
   reg  [DW-1:0]         wd_q;
   reg                   waited_q;
   wire [10:0]           tsel;
   wire [2:0]            su_raw;
   wire [4:0]            pw_raw;
   wire [2:0]            hl_raw;
   wire [2:0]            su_min;
   wire [2:0]            su_c;
   wire [4:0]            pw_c;
   wire [2:0]            hl_c;
   wire                  strobe_end;

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_n = rst_s2_q;

   // stage 0 and 1 synchronise, stage 2 is the one-clock-later copy for release
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         wait_s_q <= 3'h7;
         w16_s_q  <= 3'h7;
         ack_s_q  <= 3'h7;
      end else begin
         wait_s_q <= {wait_s_q[1:0], card_wait_n_i};
         w16_s_q  <= {w16_s_q[1:0], io_port_width16_n_i};
         ack_s_q  <= {ack_s_q[1:0], input_port_acknowledge_n_i};
      end
   end
   // wait counts as active until it has been high for one whole clock
   assign wait_act = ~wait_s_q[1] | ~wait_s_q[2];

   c16ss_fifo #(
      .WIDTH (`C16SS_CMD_W),
      .DEPTH (DEPTH),
      .AW    (4)
   ) u_fifo (
      .clk_i       (clk_sys_i),
      .rst_n_i     (rst_n),
      .in_valid_i  (cmd_valid_i),
      .in_ready_o  (cmd_ready_o),
      .in_data_i   ({cmd_write_i, cmd_io_i, cmd_attr_i, cmd_ce_i,
                     cmd_addr_i, cmd_wdata_i[`C16SS_DATA_W-1:3], cmd_wdata_i[2:0]}),
      .out_valid_o (f_valid),
      .out_ready_i (f_ready),
      .out_data_o  (f_data)
   );

   // counts are clocks of the bus clock, nominally TCYC_NS each
   assign tsel   = f_data[`C16SS_CMD_IO] ? io_timing_i : mem_timing_i;
   assign su_raw = tsel[`C16SS_TMG_SU_HI:`C16SS_TMG_SU_LO];
   assign pw_raw = tsel[`C16SS_TMG_PW_HI:`C16SS_TMG_PW_LO];
   assign hl_raw = tsel[`C16SS_TMG_HL_HI:`C16SS_TMG_HL_LO];
   // out-of-range settings are clamped to the least legal value
   assign su_min = !f_data[`C16SS_CMD_IO] ? `C16SS_SU_MEM_MIN :
                   f_data[`C16SS_CMD_WR]  ? `C16SS_SU_IOW_MIN : `C16SS_SU_IO_MIN;
   assign su_c   = (su_raw < su_min) ? su_min : su_raw;
   assign pw_c   = (pw_raw < `C16SS_PW_MIN) ? `C16SS_PW_MIN : pw_raw;
   assign hl_c   = (hl_raw < `C16SS_HL_MIN) ? `C16SS_HL_MIN : hl_raw;
   assign strobe_end = (cnt_q == pw_q) & ~wait_act;

   always @* begin
      f_ready = (st_q == ST_IDLE) & f_valid;
   end

   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q                 <= ST_IDLE;
         cnt_q                <= 5'h00;
         su_q                 <= 3'h0;
         pw_q                 <= 5'h00;
         hl_q                 <= 3'h0;
         wr_q                 <= 1'b0;
         io_q                 <= 1'b0;
         ce_q                 <= 2'h3;
         wd_q                 <= {DW{1'b0}};
         waited_q             <= 1'b0;
         done_o               <= 1'b0;
         rdata_o              <= {DW{1'b0}};
         rd_acked_o           <= 1'b0;
         port16_o             <= 1'b0;
         busy_o               <= 1'b0;
         card_address_o       <= {AW{1'b0}};
         attr_sel_n_o         <= 1'b1;
         card_enable_n_o      <= 2'h3;
         mem_read_strobe_n_o  <= 1'b1;
         mem_write_strobe_n_o <= 1'b1;
         io_read_strobe_n_o   <= 1'b1;
         io_write_strobe_n_o  <= 1'b1;
         card_data_bus_o      <= {DW{1'b0}};
         card_data_bus_oe_o   <= 1'b0;
      end else begin
         done_o <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               busy_o <= 1'b0;
               if (f_valid) begin
                  busy_o         <= 1'b1;
                  su_q           <= su_c;
                  pw_q           <= pw_c;
                  hl_q           <= hl_c;
                  wr_q           <= f_data[`C16SS_CMD_WR];
                  io_q           <= f_data[`C16SS_CMD_IO];
                  ce_q           <= ~f_data[`C16SS_CMD_CEH:`C16SS_CMD_CEL];
                  wd_q           <= f_data[`C16SS_CMD_DATA_HI:`C16SS_CMD_DATA_LO];
                  card_address_o <= f_data[`C16SS_CMD_ADDR_HI:`C16SS_CMD_ADDR_LO];
                  attr_sel_n_o   <= ~f_data[`C16SS_CMD_REG];
                  if (!f_data[`C16SS_CMD_IO]) begin
                     card_enable_n_o <= ~f_data[`C16SS_CMD_CEH:`C16SS_CMD_CEL];
                     if (f_data[`C16SS_CMD_WR]) begin
                        card_data_bus_o    <= f_data[`C16SS_CMD_DATA_HI:`C16SS_CMD_DATA_LO];
                        card_data_bus_oe_o <= 1'b1;
                     end
                  end
                  cnt_q    <= 5'h01;
                  waited_q <= 1'b0;
                  st_q     <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               // I/O card enables trail the address by one clock
               if (io_q && cnt_q == {2'h0, `C16SS_CE_LAG}) begin
                  card_enable_n_o <= ce_q;
               end
               // I/O write data is driven for the last setup-minus-two clocks
               if (io_q && wr_q && cnt_q == `C16SS_WDATA_LAG) begin
                  card_data_bus_o    <= wd_q;
                  card_data_bus_oe_o <= 1'b1;
               end
               if (io_q) begin
                  port16_o <= ~w16_s_q[1];
               end
               if (cnt_q == {2'h0, su_q}) begin
                  cnt_q <= 5'h01;
                  st_q  <= ST_PULSE;
                  if (io_q) begin
                     io_read_strobe_n_o  <= wr_q;
                     io_write_strobe_n_o <= ~wr_q;
                  end else begin
                     mem_read_strobe_n_o  <= wr_q;
                     mem_write_strobe_n_o <= ~wr_q;
                  end
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            ST_PULSE: begin
               if (io_q && !wr_q && !ack_s_q[1]) begin
                  waited_q <= 1'b1;
               end
               if (io_q) begin
                  port16_o <= ~w16_s_q[1];
               end
               if (strobe_end) begin
                  mem_read_strobe_n_o  <= 1'b1;
                  mem_write_strobe_n_o <= 1'b1;
                  io_read_strobe_n_o   <= 1'b1;
                  io_write_strobe_n_o  <= 1'b1;
                  if (!wr_q) begin
                     rdata_o <= card_data_bus_i;
                  end
                  rd_acked_o <= io_q & ~wr_q & (waited_q | ~ack_s_q[1]);
                  cnt_q      <= 5'h01;
                  st_q       <= ST_HOLD;
               end else if (cnt_q != pw_q) begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            ST_HOLD: begin
               if (cnt_q == {2'h0, hl_q}) begin
                  card_enable_n_o    <= 2'h3;
                  attr_sel_n_o       <= 1'b1;
                  card_data_bus_oe_o <= 1'b0;
                  done_o             <= 1'b1;
                  busy_o             <= 1'b0;
                  st_q               <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // c16ss_sequencer

// ### test/c16ss_card_model.sv
module c16ss_card_model (
   input  wire logic        clk_i,
   input  wire logic [3:0]  strb_n_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic [2:0]  wait_len_i,
   input  wire logic        wide_i,
   output logic             wait_n_o,
   output wire logic        width16_n_o,
   output logic             ack_n_o,
   output logic [15:0]      rdata_o,
   output logic [15:0]      wr_seen_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] left;
   logic       served;
   initial begin
      wait_n_o = 1'b1; ack_n_o = 1'b1; rdata_o = 16'h0; wr_seen_o = 16'h0; left = 3'h0;
      served = 1'b0;
   end
   // port width is settled long before the first strobe
   assign width16_n_o = !wide_i;
   // strobe order is {mem read, mem write, io read, io write}
   always @(negedge clk_i) begin
      // card data only while read strobed, else toggles so no stale value passes
      rdata_o <= (!strb_n_i[3] || !strb_n_i[1]) ? addr_i ^ 16'h5a5a : ~rdata_o;
      ack_n_o <= strb_n_i[1];
      if (!strb_n_i[2] || !strb_n_i[0]) wr_seen_o <= wdata_i;
      if (&strb_n_i) served <= 1'b0;
      if (!(&strb_n_i) && !served && wait_len_i != 3'h0) begin
         wait_n_o <= 1'b0; left <= wait_len_i; served <= 1'b1;
      end else if (left > 3'h1) left <= left - 3'h1;
      else begin
         wait_n_o <= 1'b1; left <= 3'h0;
      end
   end
endmodule // c16ss_card_model

// ### test/c16ss_sequencer_assertions.sv
module c16ss_sequencer_assertions #(parameter AW = 26, parameter DW = 16) (
   input logic          clk_sys_i,
   input logic          rst_n_i,
   input logic          done_o,
   input logic [AW-1:0] card_address_o,
   input logic          attr_sel_n_o,
   input logic [1:0]    card_enable_n_o,
   input logic          mem_read_strobe_n_o,
   input logic          mem_write_strobe_n_o,
   input logic          io_read_strobe_n_o,
   input logic          io_write_strobe_n_o,
   input logic          card_data_bus_oe_o,
   input logic          card_wait_n_i
);
   timeunit 1ns;
   timeprecision 1ns;
   wire s_low = !(mem_read_strobe_n_o & mem_write_strobe_n_o & io_read_strobe_n_o
                  & io_write_strobe_n_o);
   wire ce_on = !(&card_enable_n_o);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   property p_mem_setup;
      $fell(mem_read_strobe_n_o) || $fell(mem_write_strobe_n_o) |-> $past(ce_on);
   endproperty
   a_mem_setup: assert property (p_mem_setup) else $error("strobe without setup");
   property p_width;
      $rose(s_low) |-> s_low [*3];
   endproperty
   a_width: assert property (p_width) else $error("strobe too short");
   property p_hold;
      $fell(s_low) |-> ce_on && $stable(card_address_o) && $stable(attr_sel_n_o);
   endproperty
   a_hold: assert property (p_hold) else $error("address not held");
   property p_done;
      done_o |-> !ce_on && $past(ce_on);
   endproperty
   a_done: assert property (p_done) else $error("enable release off done");
   property p_mem_wdata;
      $fell(mem_write_strobe_n_o) |-> card_data_bus_oe_o && $past(card_data_bus_oe_o);
   endproperty
   a_mem_wdata: assert property (p_mem_wdata) else $error("write data late");
   property p_io_setup;
      $fell(io_read_strobe_n_o) || $fell(io_write_strobe_n_o)
         |-> $past(ce_on) && $past(card_address_o, 2) == card_address_o;
   endproperty
   a_io_setup: assert property (p_io_setup) else $error("io setup short");
   property p_io_wdata;
      $fell(io_write_strobe_n_o) |-> $past(card_data_bus_oe_o);
   endproperty
   a_io_wdata: assert property (p_io_wdata) else $error("io data late");
   property p_wait;
      $fell(s_low) |-> $past(card_wait_n_i) && $past(card_wait_n_i, 2);
   endproperty
   a_wait: assert property (p_wait) else $error("strobe ended in wait");
endmodule // c16ss_sequencer_assertions
bind c16ss_sequencer c16ss_sequencer_assertions #(.AW(AW), .DW(DW)) i_chk (.*);

// ### test/c16ss_sequencer_tb.sv
module c16ss_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic rd; logic io; logic wide; logic [2:0] wl;
      logic [2:0] su; logic [4:0] pw; logic [2:0] hl; logic [15:0] d; logic [25:0] a;
   } c16ss_note_t;
   logic clk_sys_i, rst_n_i, cmd_valid_i, cmd_ready_o, cmd_write_i, cmd_io_i, cmd_attr_i;
   logic [1:0] cmd_ce_i, card_enable_n_o;
   logic [25:0] cmd_addr_i, card_address_o;
   logic [15:0] cmd_wdata_i, rdata_o, card_data_bus_o, card_data_bus_i, wr_seen;
   logic [10:0] mem_timing_i, io_timing_i;
   logic done_o, rd_acked_o, port16_o, busy_o, attr_sel_n_o, card_data_bus_oe_o, wide;
   logic mem_read_strobe_n_o, mem_write_strobe_n_o, io_read_strobe_n_o, io_write_strobe_n_o;
   logic card_wait_n_i, io_port_width16_n_i, input_port_acknowledge_n_i, saw_full;
   logic [2:0] wait_len;
   c16ss_note_t nt, m;
   c16ss_note_t q[$];
   int bad_count, checks_done, w, h, s, i;
   wire s_low = !(mem_read_strobe_n_o & mem_write_strobe_n_o & io_read_strobe_n_o
                  & io_write_strobe_n_o);
   wire ce_on = !(&card_enable_n_o);
   c16ss_sequencer i_c16ss_sequencer (.*);
   c16ss_card_model i_c16ss_card_model (.clk_i(clk_sys_i),
      .strb_n_i({mem_read_strobe_n_o, mem_write_strobe_n_o, io_read_strobe_n_o,
                 io_write_strobe_n_o}),
      .addr_i(card_address_o[15:0]), .wdata_i(card_data_bus_o), .wait_len_i(wait_len),
      .wide_i(wide), .wait_n_o(card_wait_n_i), .width16_n_o(io_port_width16_n_i),
      .ack_n_o(input_port_acknowledge_n_i), .rdata_o(card_data_bus_i), .wr_seen_o(wr_seen));
   always #25 clk_sys_i = ~clk_sys_i;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // k is {io, write}; mn picks the minimum legal timing and no wait
   task automatic issue(input logic [1:0] k, input bit mn);
      logic [2:0] lo;
      int n;
      @(negedge clk_sys_i);
      lo = k[1] ? (k[0] ? 3'h3 : 3'h2) : 3'h1;
      nt.io = k[1];
      nt.rd = !k[0];
      nt.su = mn ? lo : lo + 3'($urandom % (8 - lo));
      nt.wl = mn ? 3'h0 : 3'(($urandom % 2) * (5 + $urandom % 3));
      nt.pw = (mn || nt.wl != 3'h0) ? 5'h03 : 5'(3 + $urandom % 29);
      nt.hl = mn ? 3'h1 : 3'(1 + $urandom % 7);
      nt.wide = mn ? 1'b1 : 1'($urandom % 2);
      cmd_addr_i = 26'($urandom);
      cmd_wdata_i = 16'($urandom);
      cmd_ce_i = 2'(1 + $urandom % 3);
      cmd_attr_i = 1'($urandom % 2);
      cmd_io_i = k[1];
      cmd_write_i = k[0];
      nt.d = nt.rd ? cmd_addr_i[15:0] ^ 16'h5a5a : cmd_wdata_i;
      nt.a = cmd_addr_i;
      wait_len = nt.wl;
      wide = nt.wide;
      if (k[1]) io_timing_i = {nt.hl, nt.pw, nt.su};
      else mem_timing_i = {nt.hl, nt.pw, nt.su};
      cmd_valid_i = 1'b1;
      for (n = 0; n < 300 && cmd_ready_o !== 1'b1; n++) begin
         saw_full = 1'b1;
         @(negedge clk_sys_i);
      end
      if (n == 300) begin
         bad_count++;
         close_out();
      end
      q.push_back(nt);
   endtask
   task automatic wait_idle;
      int n;
      for (n = 0; n < 3000 && q.size() != 0; n++) @(negedge clk_sys_i);
      if (q.size() != 0) begin
         bad_count++;
         close_out();
      end
   endtask
   // counts setup, strobe and hold cycles of the running card cycle
   always @(negedge clk_sys_i) begin
      if (s_low) w++;
      else if (ce_on && w > 0) h++;
      else if (ce_on) s++;
      if (done_o === 1'b1) begin
         if (q.size() == 0) chk(1, 0);
         else begin
            m = q.pop_front();
            chk(s, m.io ? m.su - 1 : m.su);
            if (m.wl == 3'h0) chk(w, m.pw);
            else chk(w > m.wl, 1);
            chk(h, m.hl);
            chk(card_address_o, m.a);
            if (m.rd) chk(rdata_o, m.d);
            else chk(wr_seen, m.d);
            if (m.io) chk(port16_o, m.wide);
            if (m.io && m.rd) chk(rd_acked_o, 1);
         end
         w = 0; h = 0; s = 0;
      end
   end
   initial begin
      clk_sys_i = 0; rst_n_i = 0; cmd_valid_i = 0; cmd_write_i = 0; cmd_io_i = 0;
      cmd_attr_i = 0; cmd_ce_i = 0; cmd_addr_i = 0; cmd_wdata_i = 0; wide = 0;
      mem_timing_i = 11'h009; io_timing_i = 11'h01a; wait_len = 0; saw_full = 0;
      w = 0; h = 0; s = 0;
      void'($urandom(5));
      repeat (16) @(posedge clk_sys_i);
      @(negedge clk_sys_i) rst_n_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      chk({busy_o, done_o, card_data_bus_oe_o, card_enable_n_o, mem_read_strobe_n_o,
           mem_write_strobe_n_o, io_read_strobe_n_o, io_write_strobe_n_o}, 32'h3f);
      for (i = 0; i < 28; i++) begin
         issue(2'(i), i < 4);
         @(negedge clk_sys_i) cmd_valid_i = 1'b0;
         wait_idle();
      end
      saw_full = 1'b0;
      for (i = 0; i < 24; i++) issue(2'h0, 1'b1);
      @(negedge clk_sys_i) cmd_valid_i = 1'b0;
      chk(saw_full, 1);
      wait_idle();
      close_out();
   end
endmodule // c16ss_sequencer_tb
